// file: dv/acp_line_model.sv
// far-side model of the four input lines: static levels and an external pacer clock
// assumes the bench sets levels and enables the clock only for external-clock tests
`timescale 1ns/1ps
// ======================================
// line driver
module acp_line_model #(
   parameter int HALF = 20
) (
   input wire logic mclk,
   input wire logic [3:0] lvl,
   input wire logic clk_on,
   output logic [3:0] din
);
   int cnt = 0;
   logic tick = 1'b0;
   // the clock stands still while disabled so the line reads as a plain level
   always @(posedge mclk) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (!clk_on) tick <= 1'b0;
      else if (cnt == HALF - 1) tick <= ~tick;
   end
   assign din = {lvl[3], clk_on ? tick : lvl[2], lvl[1:0]};
endmodule : acp_line_model

// file: dv/tb_acquisition_command_and_pacer.sv
// self-checking bench: apb register access, input port, commands and pacer rates
// assumes acp_top answers apb in one access cycle and acp_line_model drives the lines
`timescale 1ns/1ps
module tb_acquisition_command_and_pacer;
   logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, clk_on = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, pacer_pulse, acq_running, scan_tick, fifo_data_access, fifo_flush, scan_flush;
   logic [1:0] ext_gain, scan_rate;
   logic [3:0] lvl = '0, din_pin;
   int errors = 0, compares = 0, cyc = 0, last = 0, gap = 0, npace = 0, nflush = 0, nscan = 0, n;
   int sgap = 0, slast = 0;
   int dv[4] = '{4, 0, 0, 1};
   int gp[4] = '{100, 100, 1000, 80};
   logic [1:0] cs[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
   logic [1:0] rt[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
   acp_top uut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .din_pin(din_pin), .pacer_pulse(pacer_pulse), .acq_running(acq_running), .ext_gain(ext_gain),
      .scan_rate(scan_rate), .scan_tick(scan_tick), .fifo_data_access(fifo_data_access),
      .fifo_flush(fifo_flush), .scan_flush(scan_flush));
   acp_line_model lines (.mclk(mclk), .lvl(lvl), .clk_on(clk_on), .din(din_pin));
   initial forever #5 mclk = ~mclk;
   // ======================================
   // monitors: pulse counts and pacer spacing
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      nflush <= nflush + int'(fifo_flush === 1'b1);
      nscan <= nscan + int'(scan_flush === 1'b1);
      if (scan_tick === 1'b1) begin
         sgap <= cyc - slast;
         slast <= cyc;
      end
      if (pacer_pulse === 1'b1) begin
         gap <= cyc - last;
         last <= cyc;
         npace <= npace + 1;
      end
   end
   // ======================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(k < 20, 1'b1);
   endtask : apb
   task automatic idle(input int c);
      repeat (c) @(posedge mclk);
   endtask : idle
   task automatic end_of_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   // long enough for every pacer rate, well under the cycle budget
   initial begin
      #1_000_000;
      errors++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
   end
   // ======================================
   // main sequence
   initial begin
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      apb(0, 8'h24, 0);
      check(rd[7:6], 2'h2);
      check(rd[2:0], 3'h1);
      apb(0, 8'h28, 0);
      check(rd[7:0], 8'h07);
      lvl <= 4'ha;
      apb(1, 8'h0c, 32'h0000000f);
      apb(0, 8'h0c, 0);
      check(rd, 32'h0000000a);
      check(ext_gain, 2'h0);
      apb(1, 8'h20, 32'h20);
      idle(4);
      check(ext_gain, 2'h3);
      lvl <= 4'h2;
      idle(5);
      check(ext_gain, 2'h1);
      // unmapped index must be refused
      apb(0, 8'h3c, 0);
      check(err, 1'b1);
      apb(1, 8'h1c, 32'h01);
      idle(2);
      check(fifo_data_access, 1'b1);
      apb(1, 8'h1c, 32'h00);
      idle(2);
      check(fifo_data_access, 1'b0);
      apb(1, 8'h1c, 32'h20);
      apb(1, 8'h28, 32'h03);
      apb(0, 8'h28, 0);
      check(rd[7:0], 8'h03);
      apb(1, 8'h1c, 32'h40);
      idle(3);
      check(nscan, 1);
      check(nflush, 1);
      apb(0, 8'h28, 0);
      check(rd[7:0], 8'h07);
      apb(0, 8'h24, 0);
      check(rd[2:0], 3'h1);
      apb(1, 8'h14, 0);
      apb(1, 8'h18, 0);
      apb(1, 8'h20, 32'h44);
      idle(300);
      check(npace, 0);
      for (int i = 0; i < 4; i++) begin
         clk_on <= (cs[i] == 2'h0);
         apb(1, 8'h10, dv[i]);
         apb(1, 8'h20, {24'h0, cs[i], 6'h04});
         apb(1, 8'h1c, {24'h0, 5'h10, rt[i], 1'b1});
         idle(4 * gp[i] + 10);
         check(acq_running, 1'b1);
         check(scan_rate, rt[i]);
         check(gap, gp[i]);
         apb(1, 8'h1c, 32'h11);
         idle(3);
         n = npace;
         idle(2 * gp[i]);
         check(npace, n);
         check(acq_running, 1'b0);
      end
      clk_on <= 1'b0;
      apb(1, 8'h20, 32'h40);
      apb(1, 8'h1c, 32'h81);
      idle(2);
      n = npace;
      idle(2100);
      check(npace, n);
      check(sgap, acp_pkg::SCAN_100K_DIV);
      check(acq_running, 1'b1);
      apb(1, 8'h1c, 32'h11);
      idle(3);
      apb(1, 8'h1c, 32'h91);
      idle(3);
      check(acq_running, 1'b0);
      lvl <= 4'h0;
      apb(1, 8'h20, 32'h46);
      apb(1, 8'h1c, 32'h81);
      idle(10);
      check(acq_running, 1'b0);
      lvl <= 4'h1;
      idle(10);
      check(acq_running, 1'b1);
      apb(1, 8'h1c, 32'h11);
      end_of_test();
   end
endmodule : tb_acquisition_command_and_pacer

// file: logic/acp_top.sv
// acquisition command register, input port and 24-bit pacer divider behind an apb slave
// assumes host software on apb, input lines asynchronous to mclk, no wait states wanted
`timescale 1ns/1ps

module acp_top #(
   parameter int SCAN_DEPTH = acp_pkg::SCAN_DEPTH
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] din_pin,
   output logic pacer_pulse,
   output logic acq_running,
   output logic [1:0] ext_gain,
   output logic [1:0] scan_rate,
   output logic scan_tick,
   output logic fifo_data_access,
   output logic fifo_flush,
   output logic scan_flush
);
   localparam int SW = $clog2(SCAN_DEPTH + 1);

   // ==========================================================
   // state
   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] din_prev;
      logic [23:0] divisor;
      logic [23:0] count;
      logic [7:0] ctrl;
      logic [7:0] thresh;
      logic [SW-1:0] scan_fill;
      logic [11:0] pre_cnt;
      logic [11:0] scan_cnt;
      acp_pkg::acp_state_t state;
      logic access;
      logic [1:0] rate;
      logic pace;
      logic stick;
      logic fflush;
      logic sflush;
      logic fifo_empty;
      logic fifo_afull;
      logic fifo_full;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic run;
      logic [1:0] gain;
   } acp_state_s_t;

   // enum literals live in the package; local aliases keep the state comparisons short
   localparam acp_pkg::acp_state_t ACQ_IDLE = acp_pkg::ACQ_IDLE;
   localparam acp_pkg::acp_state_t ACQ_ARMED = acp_pkg::ACQ_ARMED;
   localparam acp_pkg::acp_state_t ACQ_RUN = acp_pkg::ACQ_RUN;
   acp_state_s_t s_q;
   acp_state_s_t s_d;

   // ==========================================================
   // helpers
   function automatic logic [11:0] prescale_limit(input logic [1:0] sel);
      case (sel)
         acp_pkg::CLK_5MHZ: prescale_limit = 12'(acp_pkg::DIV_5MHZ - 1);
         acp_pkg::CLK_1MHZ: prescale_limit = 12'(acp_pkg::DIV_1MHZ - 1);
         default: prescale_limit = 12'(acp_pkg::DIV_100KHZ - 1);
      endcase
   endfunction : prescale_limit

   function automatic logic [11:0] scan_limit(input logic [1:0] r);
      case (r)
         2'h0: scan_limit = 12'(acp_pkg::SCAN_100K_DIV - 1);
         2'h2: scan_limit = 12'(acp_pkg::SCAN_25K_DIV - 1);
         default: scan_limit = 12'(acp_pkg::SCAN_50K_DIV - 1);
      endcase
   endfunction : scan_limit

   // ==========================================================
   // next state
   logic setup_w;
   logic access_w;
   logic wr;
   logic [3:0] idx;
   logic src_tick;
   logic ext_edge;
   logic [1:0] clk_sel;
   logic [7:0] wb;

   always_comb begin
      s_d = s_q;
      setup_w = psel && !penable;
      access_w = psel && penable;
      idx = paddr[5:2];
      wr = access_w && pwrite && s_q.ready && (paddr[7:6] == 2'h0);
      wb = pwdata[7:0];
      clk_sel = s_q.ctrl[acp_pkg::CTRL_CLK_LSB +: 2];
      s_d.sync1 = din_pin;
      s_d.sync2 = s_q.sync1;
      s_d.din_prev = s_q.sync2;
      s_d.pace = 1'b0;
      s_d.stick = 1'b0;
      s_d.fflush = 1'b0;
      s_d.sflush = 1'b0;
      s_d.ready = setup_w;
      s_d.err = 1'b0;

      // source pulse: external line 2 rising edge or internal prescaler
      src_tick = 1'b0;
      if (clk_sel == acp_pkg::CLK_EXTERNAL) begin
         src_tick = s_q.sync2[2] && !s_q.din_prev[2];
      end else if (s_q.pre_cnt >= prescale_limit(clk_sel)) begin
         src_tick = 1'b1;
         s_d.pre_cnt = 12'h000;
      end else begin
         s_d.pre_cnt = s_q.pre_cnt + 12'h001;
      end
      // trigger edge on line 0, polarity from control
      ext_edge = s_q.ctrl[acp_pkg::CTRL_EDGE_BIT] ?
         (!s_q.sync2[0] && s_q.din_prev[0]) : (s_q.sync2[0] && !s_q.din_prev[0]);

      // apb read answer in setup cycle; ready one cycle later
      if (setup_w) begin
         s_d.rdata = 32'h00000000;
         case (idx)
            acp_pkg::IDX_INPUT_LEVELS: s_d.rdata = {28'h0000000, s_q.sync2};
            acp_pkg::IDX_PACER_CTRL: s_d.rdata = {24'h000000, s_q.ctrl};
            acp_pkg::IDX_ACQ_STATUS: s_d.rdata = {24'h000000, s_q.state == ACQ_IDLE,
               s_q.state == ACQ_RUN, 3'h0, s_q.fifo_full, s_q.fifo_afull, s_q.fifo_empty};
            acp_pkg::IDX_THRESHOLD: s_d.rdata = {24'h000000, s_q.thresh};
            acp_pkg::IDX_DIV_LOW, acp_pkg::IDX_DIV_MID, acp_pkg::IDX_DIV_HIGH,
            acp_pkg::IDX_ACQ_CMD: s_d.rdata = 32'h00000000;
            default: s_d.err = 1'b1;
         endcase
         // upper address bits must be zero, else a mapped index would alias
         if (paddr[7:6] != 2'h0) begin
            s_d.err = 1'b1;
         end
      end

      // pacer counting while running; pulses only in continuous mode
      if (s_q.state == ACQ_RUN && src_tick) begin
         if (s_q.count == 24'h000000) begin
            s_d.count = s_q.divisor;
            s_d.pace = s_q.ctrl[acp_pkg::CTRL_MODE_BIT];
         end else begin
            s_d.count = s_q.count - 24'h000001;
         end
      end
      // scan rate timer while running
      if (s_q.state == ACQ_RUN) begin
         if (s_q.scan_cnt >= scan_limit(s_q.rate)) begin
            s_d.scan_cnt = 12'h000;
            s_d.stick = 1'b1;
         end else begin
            s_d.scan_cnt = s_q.scan_cnt + 12'h001;
         end
      end
      // armed: wait for external edge
      if (s_q.state == ACQ_ARMED && ext_edge) begin
         s_d.state = ACQ_RUN;
         s_d.count = s_q.divisor;
         s_d.pace = s_q.ctrl[acp_pkg::CTRL_MODE_BIT];
         s_d.scan_cnt = 12'h000;
      end

      if (wr) begin
         case (idx)
            acp_pkg::IDX_DIV_LOW: s_d.divisor[7:0] = wb;
            acp_pkg::IDX_DIV_MID: s_d.divisor[15:8] = wb;
            acp_pkg::IDX_DIV_HIGH: s_d.divisor[23:16] = wb;
            acp_pkg::IDX_PACER_CTRL: s_d.ctrl = wb;
            acp_pkg::IDX_THRESHOLD: s_d.thresh = wb;
            acp_pkg::IDX_ACQ_CMD: begin
               s_d.access = wb[acp_pkg::CMD_ACCESS_BIT];
               if (wb[acp_pkg::CMD_FLUSH_FIFO_BIT]) begin
                  s_d.fflush = 1'b1;
                  s_d.fifo_empty = 1'b1;
                  s_d.fifo_afull = 1'b0;
                  s_d.fifo_full = 1'b0;
                  s_d.thresh = acp_pkg::THRESH_DEFAULT;
               end
               if (wb[acp_pkg::CMD_FLUSH_SCAN_BIT]) begin
                  s_d.sflush = 1'b1;
                  s_d.scan_fill = '0;
               end
               if (wb[acp_pkg::CMD_STOP_BIT]) begin
                  s_d.state = ACQ_IDLE;
                  s_d.pace = 1'b0;
               end else if (wb[acp_pkg::CMD_TRIG_BIT]) begin
                  s_d.rate = wb[acp_pkg::CMD_RATE_LSB +: 2];
                  if (s_q.ctrl[acp_pkg::CTRL_SRC_BIT]) begin
                     s_d.state = ACQ_ARMED;
                  end else begin
                     s_d.state = ACQ_RUN;
                     s_d.count = s_q.divisor;
                     s_d.pace = s_q.ctrl[acp_pkg::CTRL_MODE_BIT];
                     s_d.scan_cnt = 12'h000;
                  end
               end
            end
            default: s_d.err = 1'b0;
         endcase
      end
      // status outputs registered so every pin comes from a flop
      s_d.run = (s_d.state == ACQ_RUN);
      s_d.gain = s_q.ctrl[acp_pkg::CTRL_EXP_BIT] ? {s_q.sync2[3], s_q.sync2[1]} : 2'h0;
   end

   // ==========================================================
   // registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.state <= ACQ_IDLE;
         s_q.thresh <= acp_pkg::THRESH_DEFAULT;
         s_q.fifo_empty <= 1'b1;
         s_q.divisor <= acp_pkg::DIVISOR_RESET;
         s_q.ctrl <= acp_pkg::CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs, all from flops
   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.err;
   assign pacer_pulse = s_q.pace;
   assign acq_running = s_q.run;
   // gain is only meaningful in expansion mode; zero otherwise
   assign ext_gain = s_q.gain;
   assign scan_rate = s_q.rate;
   assign scan_tick = s_q.stick;
   assign fifo_data_access = s_q.access;
   assign fifo_flush = s_q.fflush;
   assign scan_flush = s_q.sflush;

   // ==========================================================
   // checks
   stop_wins_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_ACQ_CMD && wb[acp_pkg::CMD_STOP_BIT] |=> !acq_running ##1 !pacer_pulse)
      else $error("stop did not end acquisition");
   no_pulse_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
      $past(s_q.state) == ACQ_IDLE && s_q.state == ACQ_IDLE |-> !pacer_pulse)
      else $error("pacer pulse while idle");
   sw_trig_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_ACQ_CMD && wb == 8'h81 && !s_q.ctrl[acp_pkg::CTRL_SRC_BIT] |=> acq_running)
      else $error("software trigger did not start");
   arm_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_ACQ_CMD && wb == 8'h81 && s_q.ctrl[acp_pkg::CTRL_SRC_BIT] |=> s_q.state == ACQ_ARMED)
      else $error("arm did not take effect");
   flush_flags_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_ACQ_CMD && wb[acp_pkg::CMD_FLUSH_FIFO_BIT] |=>
      fifo_flush && s_q.fifo_empty && !s_q.fifo_full && s_q.thresh == 8'h07 ##1 !fifo_flush)
      else $error("fifo flush flags wrong");
   cmd_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
      scan_flush |=> !scan_flush) else $error("flush pulse not single");
   access_latch_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_ACQ_CMD |=> fifo_data_access == $past(wb[0]))
      else $error("access bit not latched");
   reload_a: assert property (@(posedge mclk) disable iff (!arst_n)
      acq_running && src_tick && s_q.count == 24'h000000 && !wr |=> s_q.count == s_q.divisor)
      else $error("counter did not reload");
   input_upper_a: assert property (@(posedge mclk) disable iff (!arst_n)
      pready && !pwrite && paddr[5:2] == acp_pkg::IDX_INPUT_LEVELS |-> prdata[31:4] == 28'h0000000)
      else $error("input port upper bits not zero");

   // ==========================================================
   // bus answer: one wait-free access, error only with ready
   ready_after_a: assert property (@(posedge mclk) disable iff (!arst_n)
      psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_single_a: assert property (@(posedge mclk) disable iff (!arst_n)
      pready |=> !pready)
      else $error("ready held too long");
   err_with_ready_a: assert property (@(posedge mclk) disable iff (!arst_n)
      pslverr |-> pready)
      else $error("error without ready");
   unmapped_index_a: assert property (@(posedge mclk) disable iff (!arst_n)
      psel && !penable && paddr[5:2] > acp_pkg::IDX_THRESHOLD |=> pslverr)
      else $error("unmapped index not refused");
   upper_addr_a: assert property (@(posedge mclk) disable iff (!arst_n)
      psel && !penable && paddr[7:6] != 2'h0 |=> pslverr)
      else $error("upper address bits not refused");
   mapped_ok_a: assert property (@(posedge mclk) disable iff (!arst_n)
      psel && !penable && paddr[7:6] == 2'h0 && paddr[5:2] >= acp_pkg::IDX_INPUT_LEVELS &&
      paddr[5:2] <= acp_pkg::IDX_THRESHOLD |=> !pslverr)
      else $error("mapped index refused");
   input_live_a: assert property (@(posedge mclk) disable iff (!arst_n)
      pready && !pwrite && paddr == {2'h0, acp_pkg::IDX_INPUT_LEVELS, 2'h0} |-> prdata[3:0] == $past(s_q.sync2))
      else $error("input port not live levels");
   wo_ports_a: assert property (@(posedge mclk) disable iff (!arst_n)
      pready && !pwrite && paddr[5:2] >= acp_pkg::IDX_DIV_LOW && paddr[5:2] <= acp_pkg::IDX_ACQ_CMD |->
      prdata == 32'h00000000)
      else $error("write-only port read back");

   // ==========================================================
   // register writes
   div_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_DIV_LOW |=> s_q.divisor[7:0] == $past(wb))
      else $error("divisor low byte not written");
   div_mid_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_DIV_MID |=> s_q.divisor[15:8] == $past(wb))
      else $error("divisor middle byte not written");
   div_high_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_DIV_HIGH |=> s_q.divisor[23:16] == $past(wb))
      else $error("divisor high byte not written");
   ctrl_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_PACER_CTRL |=> s_q.ctrl == $past(wb))
      else $error("control not written");
   thresh_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_THRESHOLD |=> s_q.thresh == $past(wb))
      else $error("threshold not written");

   // ==========================================================
   // pacer and acquisition state
   oneshot_silent_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !$past(s_q.ctrl[acp_pkg::CTRL_MODE_BIT]) |-> !pacer_pulse)
      else $error("pacer pulse in one-shot mode");
   trig_first_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_ACQ_CMD && wb[acp_pkg::CMD_TRIG_BIT] && !wb[acp_pkg::CMD_STOP_BIT] &&
      !s_q.ctrl[acp_pkg::CTRL_SRC_BIT] && s_q.ctrl[acp_pkg::CTRL_MODE_BIT] |=>
      pacer_pulse && s_q.count == $past(s_q.divisor))
      else $error("trigger not first pulse");
   count_down_a: assert property (@(posedge mclk) disable iff (!arst_n)
      acq_running && src_tick && s_q.count != 24'h000000 && !wr |=> s_q.count == $past(s_q.count) - 24'h000001)
      else $error("counter did not count down");
   count_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
      acq_running && !src_tick && !wr |=> $stable(s_q.count))
      else $error("counter moved without source");
   ext_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
      s_q.state == ACQ_ARMED && ext_edge && !wr |=> acq_running)
      else $error("armed edge did not start");
   armed_wait_a: assert property (@(posedge mclk) disable iff (!arst_n)
      s_q.state == ACQ_ARMED && !ext_edge && !wr |=> s_q.state == ACQ_ARMED)
      else $error("armed state left without edge");
   run_holds_a: assert property (@(posedge mclk) disable iff (!arst_n)
      acq_running && !(wr && idx == acp_pkg::IDX_ACQ_CMD) |=> acq_running)
      else $error("acquisition ended without command");
   stop_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_ACQ_CMD && wb[acp_pkg::CMD_STOP_BIT] |=> s_q.state == ACQ_IDLE)
      else $error("stop did not idle");
   rate_latch_a: assert property (@(posedge mclk) disable iff (!arst_n)
      wr && idx == acp_pkg::IDX_ACQ_CMD && wb[acp_pkg::CMD_TRIG_BIT] && !wb[acp_pkg::CMD_STOP_BIT] |=>
      scan_rate == $past(wb[acp_pkg::CMD_RATE_LSB +: 2]))
      else $error("scan rate not latched");
   scan_quiet_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !$past(acq_running) |-> !scan_tick)
      else $error("scan tick while not running");
   fifo_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
      fifo_flush |=> !fifo_flush)
      else $error("fifo flush pulse not single");
   scan_cause_a: assert property (@(posedge mclk) disable iff (!arst_n)
      scan_flush |-> $past(wr && idx == acp_pkg::IDX_ACQ_CMD && wb[acp_pkg::CMD_FLUSH_SCAN_BIT]))
      else $error("scan flush without command");

   // ==========================================================
   // expansion gain follows lines 3 and 1 only when enabled
   gain_follow_a: assert property (@(posedge mclk) disable iff (!arst_n)
      $past(s_q.ctrl[acp_pkg::CTRL_EXP_BIT]) |-> ext_gain == $past({s_q.sync2[3], s_q.sync2[1]}))
      else $error("gain does not follow lines");
   gain_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !$past(s_q.ctrl[acp_pkg::CTRL_EXP_BIT]) |-> ext_gain == 2'h0)
      else $error("gain not zero outside expansion");
endmodule : acp_top

// file: shared/acp_pkg.sv
// constants for the acquisition command and pacer block
// assumes one 100 MHz clock and byte-wide registers on 32-bit apb words
package acp_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [3:0] IDX_INPUT_LEVELS = 4'h3;
   localparam logic [3:0] IDX_DIV_LOW = 4'h4;
   localparam logic [3:0] IDX_DIV_MID = 4'h5;
   localparam logic [3:0] IDX_DIV_HIGH = 4'h6;
   localparam logic [3:0] IDX_ACQ_CMD = 4'h7;
   // control, status and threshold registers that the block needs but no offset is printed for
   localparam logic [3:0] IDX_PACER_CTRL = 4'h8;
   localparam logic [3:0] IDX_ACQ_STATUS = 4'h9;
   localparam logic [3:0] IDX_THRESHOLD = 4'ha;
   // command register fields
   localparam int CMD_ACCESS_BIT = 0;
   localparam int CMD_RATE_LSB = 1;
   localparam int CMD_STOP_BIT = 4;
   localparam int CMD_FLUSH_SCAN_BIT = 5;
   localparam int CMD_FLUSH_FIFO_BIT = 6;
   localparam int CMD_TRIG_BIT = 7;
   // pacer control fields
   localparam int CTRL_EDGE_BIT = 0;
   localparam int CTRL_SRC_BIT = 1;
   localparam int CTRL_MODE_BIT = 2;
   localparam int CTRL_EXP_BIT = 5;
   localparam int CTRL_CLK_LSB = 6;
   // clock source codes
   localparam logic [1:0] CLK_EXTERNAL = 2'h0;
   localparam logic [1:0] CLK_5MHZ = 2'h1;
   localparam logic [1:0] CLK_1MHZ = 2'h2;
   localparam logic [1:0] CLK_100KHZ = 2'h3;
   localparam int MCLK_HZ = 100_000_000;
   localparam int DIV_5MHZ = MCLK_HZ / 5_000_000;
   localparam int DIV_1MHZ = MCLK_HZ / 1_000_000;
   localparam int DIV_100KHZ = MCLK_HZ / 100_000;
   // scan rate codes, 11 behaves like 01
   localparam int SCAN_100K_DIV = MCLK_HZ / 100_000;
   localparam int SCAN_50K_DIV = MCLK_HZ / 50_000;
   localparam int SCAN_25K_DIV = MCLK_HZ / 25_000;
   // reset values
   localparam logic [7:0] THRESH_DEFAULT = 8'h07;
   localparam logic [23:0] DIVISOR_RESET = 24'h000000;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int SCAN_DEPTH = 2048;
   typedef enum logic [1:0] {ACQ_IDLE, ACQ_ARMED, ACQ_RUN} acp_state_t;
endpackage : acp_pkg
